// file: ffp_fetch_ctrl.sv
`timescale 1ns/100ps
// Operation
// - Prefetch off after reset; on only while option bit 0 is one.
// - Each instruction fetch reads one full 64-bit array word per access.
// - Fetch address is aligned down to the enclosing 64-bit boundary.
// - With prefetch on, words sit in a two-entry 64-bit buffer.
// - Instructions are served from a buffered 64-bit word.
// - Next sequential word is fetched in background while buffer has room.
// - A discontinuity or clearing prefetch enable aborts prefetch and flushes buffer.
// - Discontinuity into flash or OTP restarts prefetch at the target.
// - Discontinuity outside flash and OTP leaves prefetch idle until return.
// - Data reads of either space bypass the prefetch buffer.
// - A bypassing data read leaves buffer contents intact.
// - A data read waits until an in-flight prefetch access finishes.
// - Prefetch enable covers fetches from both flash and OTP.
// - No hardware guard against configuration writes during flash activity.
// - CPU writes need unlock and are blocked after lock; reads always allowed.
// - Debug port writes succeed without the unlock.
// - Configuration registers accept 16-bit and 32-bit accesses.
// - Flash-resident code may read configuration registers.
// - CPU writes into flash or OTP are discarded in one cycle when no prefetch access is in flight.
module ffp_fetch_ctrl (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire ffp_pkg::ffp_req_s REQ_I,
  input wire logic DISCONT_I,
  output logic READY_O,
  output logic [63:0] RDATA_O,
  input wire logic REG_SEL_I,
  input wire logic REG_WR_I,
  input wire logic REG_WIDE_I,
  input wire logic REG_DEBUG_I,
  input wire logic UNLOCK_I,
  input wire logic LOCK_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic ARR_REQ_O,
  output logic ARR_OTP_O,
  output logic [18:0] ARR_WADDR_O,
  input wire logic [63:0] ARR_DATA_I
);
  import ffp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [15:0] opt_r, opt_nxt, pwr_r, pwr_nxt, slp_r, slp_nxt;
  logic [15:0] act_r, act_nxt, aws_r, aws_nxt, ows_r, ows_nxt;
  logic unlocked_r, unlocked_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Register read word for one index.
  function automatic logic [15:0] reg_word(input logic [15:0] a, input logic [15:0] o, input logic [15:0] p,
                                           input logic [15:0] s, input logic [15:0] c, input logic [15:0] w,
                                           input logic [15:0] t, input logic [15:0] st);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      FFP_OFS_OPTION: v = o;
      FFP_OFS_POWER: v = p;
      FFP_OFS_STATE: v = st;
      FFP_OFS_SLP_STBY: v = s;
      FFP_OFS_STBY_ACT: v = c;
      FFP_OFS_ARRAY_WS: v = w;
      FFP_OFS_OTP_WS: v = t;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  logic wr_ok;
  logic [15:0] st_word;
  // Next register values; writes need unlock or the debug port.
  always_comb begin
    opt_nxt = opt_r;
    pwr_nxt = pwr_r;
    slp_nxt = slp_r;
    act_nxt = act_r;
    aws_nxt = aws_r;
    ows_nxt = ows_r;
    unlocked_nxt = unlocked_r;
    if (UNLOCK_I) begin
      unlocked_nxt = 1'b1;
    end else if (LOCK_I) begin
      unlocked_nxt = 1'b0;
    end
    st_word = {14'h0000, pwr_r[1:0]};
    wr_ok = REG_SEL_I && REG_WR_I && (unlocked_r || REG_DEBUG_I);
    rdata_nxt = rdata_r;
    if (REG_SEL_I && !REG_WR_I) begin
      // Reads are always served, also to flash-resident code.
      rdata_nxt[15:0] = reg_word(REG_ADDR_I, opt_r, pwr_r, slp_r, act_r, aws_r, ows_r, st_word);
      rdata_nxt[31:16] = REG_WIDE_I ? reg_word(REG_ADDR_I + 16'h0001, opt_r, pwr_r, slp_r, act_r, aws_r, ows_r,
                                               st_word) : 16'h0000;
    end
    if (wr_ok) begin
      for (int k = 0; k < 2; k++) begin
        if (k == 0 || REG_WIDE_I) begin
          case (REG_ADDR_I + 16'(k))
            FFP_OFS_OPTION: opt_nxt = {15'h0000, REG_WDATA_I[16*k+FFP_POS_PREFETCH_ENABLE]};
            FFP_OFS_POWER: pwr_nxt = {14'h0000, REG_WDATA_I[16*k+:2]};
            FFP_OFS_SLP_STBY: slp_nxt = REG_WDATA_I[16*k+:16];
            FFP_OFS_STBY_ACT: act_nxt = REG_WDATA_I[16*k+:16];
            FFP_OFS_ARRAY_WS: aws_nxt = REG_WDATA_I[16*k+:16];
            FFP_OFS_OTP_WS: ows_nxt = REG_WDATA_I[16*k+:16];
            default: ;
          endcase
        end
      end
    end
  end

  // Register storage.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      opt_r <= FFP_RST_OPTION;
      pwr_r <= FFP_RST_POWER;
      slp_r <= FFP_RST_SLP_STBY;
      act_r <= FFP_RST_STBY_ACT;
      aws_r <= FFP_RST_ARRAY_WS;
      ows_r <= FFP_RST_OTP_WS;
      unlocked_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else if (CE_I) begin
      opt_r <= opt_nxt;
      pwr_r <= pwr_nxt;
      slp_r <= slp_nxt;
      act_r <= act_nxt;
      aws_r <= aws_nxt;
      ows_r <= ows_nxt;
      unlocked_r <= unlocked_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign REG_RDATA_O = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Fetch path and prefetch buffer.
  ffp_state_e st_r, st_nxt;
  logic [63:0] buf_r [2], buf_nxt [2];
  logic [18:0] btag_r [2], btag_nxt [2];
  logic [1:0] bval_r, bval_nxt;
  logic [18:0] pf_addr_r, pf_addr_nxt, acc_addr_r, acc_addr_nxt, last_row_r, last_row_nxt;
  logic pf_run_r, pf_run_nxt, acc_otp_r, acc_otp_nxt, acc_drop_r, acc_drop_nxt;
  logic [3:0] wait_r, wait_nxt;
  logic ready_r, ready_nxt, areq_r, areq_nxt;
  logic [63:0] rdat_r, rdat_nxt;

  logic pipe_on, in_rng, is_otp, hit0, hit1;
  logic [18:0] waddr;
  logic [3:0] ws;

  // Decode of the current request.
  always_comb begin
    pipe_on = opt_r[FFP_POS_PREFETCH_ENABLE];
    // Addresses count 16-bit units, so a 64-bit word drops the two low bits.
    // Bit 21 is set throughout flash and OTP and is implied on the array side.
    waddr = REQ_I.addr[20:2];
    is_otp = REQ_I.addr >= FFP_OTP_LO && REQ_I.addr <= FFP_OTP_HI;
    in_rng = is_otp || (REQ_I.addr >= FFP_FLASH_LO && REQ_I.addr <= FFP_FLASH_HI);
    hit0 = bval_r[0] && btag_r[0] == waddr;
    hit1 = bval_r[1] && btag_r[1] == waddr;
  end

  // Wait states for a new array access; OTP has no paged mode.
  function automatic logic [3:0] pick_ws(input logic otp, input logic [18:0] a, input logic [18:0] row,
                                         input logic [15:0] w, input logic [15:0] t);
    logic [3:0] v;
    // A paged access stays inside the row of the previous access.
    v = otp ? t[3:0] : (((a >> (FFP_ROW_SHIFT - 2)) == (row >> (FFP_ROW_SHIFT - 2))) ? w[FFP_POS_PAGED_WS+:4] :
                        w[FFP_POS_RANDOM_WS+:4]);
    return v;
  endfunction

  // Access sequencer next state.
  always_comb begin
    st_nxt = st_r;
    buf_nxt = buf_r;
    btag_nxt = btag_r;
    bval_nxt = bval_r;
    pf_addr_nxt = pf_addr_r;
    pf_run_nxt = pf_run_r;
    acc_addr_nxt = acc_addr_r;
    acc_otp_nxt = acc_otp_r;
    acc_drop_nxt = acc_drop_r;
    last_row_nxt = last_row_r;
    wait_nxt = wait_r;
    ready_nxt = 1'b0;
    areq_nxt = 1'b0;
    rdat_nxt = rdat_r;
    ws = pick_ws(is_otp, waddr, last_row_r, aws_r, ows_r);
    if (DISCONT_I || !pipe_on) begin
      bval_nxt = 2'b00;
      pf_run_nxt = 1'b0;
      if (st_r == FFP_PREF) begin
        acc_drop_nxt = 1'b1;
      end
    end
    case (st_r)
      FFP_IDLE: begin
        if (ready_r) begin
          // The request still stands in its answer cycle; it has been served already.
          st_nxt = FFP_IDLE;
        end else if (REQ_I.wr) begin
          ready_nxt = 1'b1;
        end else if (REQ_I.data_rd && in_rng) begin
          st_nxt = FFP_DATA;
          // The array request rises with the access, so a zero-wait access still shows it.
          areq_nxt = 1'b1;
          acc_addr_nxt = waddr;
          acc_otp_nxt = is_otp;
          wait_nxt = ws;
        end else if (REQ_I.fetch && in_rng) begin
          if (pipe_on && !DISCONT_I && (hit0 || hit1)) begin
            rdat_nxt = hit0 ? buf_r[0] : buf_r[1];
            ready_nxt = 1'b1;
            bval_nxt[hit0 ? 0 : 1] = 1'b0;
            pf_run_nxt = 1'b1;
          end else begin
            st_nxt = FFP_FETCH;
            areq_nxt = 1'b1;
            acc_addr_nxt = waddr;
            acc_otp_nxt = is_otp;
            wait_nxt = ws;
            pf_addr_nxt = waddr + 19'h1;
            pf_run_nxt = pipe_on;
          end
        end else if (pipe_on && pf_run_r && !DISCONT_I && bval_r != 2'b11) begin
          st_nxt = FFP_PREF;
          areq_nxt = 1'b1;
          acc_addr_nxt = pf_addr_r;
          acc_otp_nxt = pf_addr_r >= FFP_OTP_LO[20:2];
          acc_drop_nxt = 1'b0;
          wait_nxt = pick_ws(pf_addr_r >= FFP_OTP_LO[20:2], pf_addr_r, last_row_r, aws_r, ows_r);
        end
      end
      FFP_FETCH, FFP_DATA, FFP_PREF: begin
        areq_nxt = 1'b1;
        if (wait_r != 4'h0) begin
          wait_nxt = wait_r - 4'h1;
        end else begin
          st_nxt = FFP_IDLE;
          areq_nxt = 1'b0;
          last_row_nxt = acc_addr_r;
          if (st_r == FFP_PREF) begin
            if (!acc_drop_nxt) begin
              buf_nxt[bval_r[0] ? 1 : 0] = ARR_DATA_I;
              btag_nxt[bval_r[0] ? 1 : 0] = acc_addr_r;
              bval_nxt[bval_r[0] ? 1 : 0] = 1'b1;
              pf_addr_nxt = acc_addr_r + 19'h1;
            end
          end else begin
            rdat_nxt = ARR_DATA_I;
            ready_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = FFP_IDLE;
    endcase
  end

  // Access sequencer storage.
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      st_r <= FFP_IDLE;
      buf_r <= '{64'h0, 64'h0};
      btag_r <= '{19'h0, 19'h0};
      bval_r <= 2'b00;
      pf_addr_r <= 19'h00000;
      pf_run_r <= 1'b0;
      acc_addr_r <= 19'h00000;
      acc_otp_r <= 1'b0;
      acc_drop_r <= 1'b0;
      last_row_r <= 19'h7FFFF;
      wait_r <= 4'h0;
      ready_r <= 1'b0;
      areq_r <= 1'b0;
      rdat_r <= 64'h0;
    end else if (CE_I) begin
      st_r <= st_nxt;
      buf_r <= buf_nxt;
      btag_r <= btag_nxt;
      bval_r <= bval_nxt;
      pf_addr_r <= pf_addr_nxt;
      pf_run_r <= pf_run_nxt;
      acc_addr_r <= acc_addr_nxt;
      acc_otp_r <= acc_otp_nxt;
      acc_drop_r <= acc_drop_nxt;
      last_row_r <= last_row_nxt;
      wait_r <= wait_nxt;
      ready_r <= ready_nxt;
      areq_r <= areq_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign READY_O = ready_r;
  assign RDATA_O = rdat_r;
  assign ARR_REQ_O = areq_r;
  assign ARR_OTP_O = acc_otp_r;
  assign ARR_WADDR_O = acc_addr_r;
endmodule

// file: ffp_fetch_monitor.sv
`timescale 1ns/100ps
module ffp_fetch_monitor (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire ffp_pkg::ffp_req_s REQ_I,
  input wire logic DISCONT_I,
  input wire logic READY_O,
  input wire logic [63:0] RDATA_O,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic ARR_REQ_O,
  input wire logic [18:0] ARR_WADDR_O,
  input wire logic [63:0] ARR_DATA_I
);
  import ffp_pkg::*;
  logic in_rng;
  // Flags a request address that lies in flash or OTP.
  assign in_rng = (REQ_I.addr >= FFP_FLASH_LO && REQ_I.addr <= FFP_FLASH_HI) ||
    (REQ_I.addr >= FFP_OTP_LO && REQ_I.addr <= FFP_OTP_HI);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  ////////////////////////////////////////////////////////////
  // Answer timing, data path and abort behaviour.
  ready_pulse_a: assert property (READY_O |=> !READY_O) else $error("ready held too long");
  write_fast_a: assert property (REQ_I.wr && !ARR_REQ_O && !READY_O |=> READY_O && !ARR_REQ_O)
    else $error("write not done in one cycle");
  read_data_a: assert property (READY_O && REQ_I.data_rd |-> $past(ARR_REQ_O) &&
    $past(ARR_WADDR_O) == REQ_I.addr[20:2] && RDATA_O == $past(ARR_DATA_I)) else $error("read not from array");
  read_wait_a: assert property (REQ_I.data_rd && ARR_REQ_O && ARR_WADDR_O != REQ_I.addr[20:2] |=> !READY_O)
    else $error("read answered during prefetch");
  reset_clear_a: assert property (disable iff (1'b0) !RESET_N_I |=> !READY_O && !ARR_REQ_O && REG_RDATA_O == 32'h0)
    else $error("outputs not cleared by reset");
  restart_tgt_a: assert property (DISCONT_I && REQ_I.fetch && in_rng |=> ##[0:40] ARR_REQ_O &&
    ARR_WADDR_O == REQ_I.addr[20:2]) else $error("no restart at target");
  outside_idle_a: assert property (DISCONT_I && REQ_I.fetch && !in_rng |=>
    !READY_O [*3] ##1 (!ARR_REQ_O && !READY_O) [*5]) else $error("activity after outside branch");
  addr_hold_a: assert property ($rose(ARR_REQ_O) && !DISCONT_I |=> ARR_REQ_O && $stable(ARR_WADDR_O))
    else $error("array address moved mid access");
  // Main scenarios.
  cover property (READY_O && REQ_I.fetch);
  cover property (DISCONT_I && !in_rng);
  cover property (REQ_I.data_rd && ARR_REQ_O);
endmodule
bind ffp_fetch_ctrl ffp_fetch_monitor mon_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REQ_I(REQ_I),
  .DISCONT_I(DISCONT_I), .READY_O(READY_O), .RDATA_O(RDATA_O), .REG_RDATA_O(REG_RDATA_O),
  .ARR_REQ_O(ARR_REQ_O), .ARR_WADDR_O(ARR_WADDR_O), .ARR_DATA_I(ARR_DATA_I));

// file: ffp_flash_model.sv
`timescale 1ns/100ps
module ffp_flash_model (
  input wire logic clk_i,
  input wire logic arr_req_i,
  input wire logic arr_otp_i,
  input wire logic [18:0] arr_waddr_i,
  output logic [63:0] arr_data_o
);
  logic [63:0] junk_r = 64'h0;
  // Scrambles the idle bus every cycle so stale data never looks valid.
  always_ff @(posedge clk_i) begin
    junk_r <= {junk_r[62:0], ~junk_r[63]};
  end
  // Serves a whole 64-bit word made from the word address and bank select.
  assign arr_data_o = arr_req_i ? {arr_otp_i, 12'h0, arr_waddr_i, 13'h0, ~arr_waddr_i} : junk_r;
endmodule

// file: ffp_pkg.sv
package ffp_pkg;
  // Register word addresses, 16-bit word index on the peripheral frame.
  localparam logic [15:0] FFP_OFS_OPTION = 16'h0A80;
  localparam logic [15:0] FFP_OFS_RSVD = 16'h0A81;
  localparam logic [15:0] FFP_OFS_POWER = 16'h0A82;
  localparam logic [15:0] FFP_OFS_STATE = 16'h0A83;
  localparam logic [15:0] FFP_OFS_SLP_STBY = 16'h0A84;
  localparam logic [15:0] FFP_OFS_STBY_ACT = 16'h0A85;
  localparam logic [15:0] FFP_OFS_ARRAY_WS = 16'h0A86;
  localparam logic [15:0] FFP_OFS_OTP_WS = 16'h0A87;
  // Field positions.
  localparam int FFP_POS_PREFETCH_ENABLE = 0;
  localparam int FFP_POS_RANDOM_WS = 8;
  localparam int FFP_POS_PAGED_WS = 0;
  // Reset values.
  localparam logic [15:0] FFP_RST_OPTION = 16'h0000;
  localparam logic [15:0] FFP_RST_POWER = 16'h0000;
  localparam logic [15:0] FFP_RST_SLP_STBY = 16'h01FF;
  localparam logic [15:0] FFP_RST_STBY_ACT = 16'h01FF;
  localparam logic [15:0] FFP_RST_ARRAY_WS = 16'h0F0F;
  localparam logic [15:0] FFP_RST_OTP_WS = 16'h001F;
  // Address window decode: flash range and OTP range, 22-bit word addresses.
  localparam logic [21:0] FFP_FLASH_LO = 22'h300000;
  localparam logic [21:0] FFP_FLASH_HI = 22'h33FFFF;
  localparam logic [21:0] FFP_OTP_LO = 22'h380400;
  localparam logic [21:0] FFP_OTP_HI = 22'h3807FF;
  // Row size as a shift of the 16-bit unit address: a 2048-bit row holds 32 64-bit words.
  localparam int FFP_ROW_SHIFT = 7;

  // Request from the CPU side.
  typedef struct packed {
    logic fetch;
    logic data_rd;
    logic wr;
    logic [21:0] addr;
  } ffp_req_s;

  // Array access state.
  typedef enum logic [3:0] {
    FFP_IDLE = 4'b0001,
    FFP_FETCH = 4'b0010,
    FFP_DATA = 4'b0100,
    FFP_PREF = 4'b1000
  } ffp_state_e;
endpackage

// file: flash_fetch_prefetch_ctrl_test.sv
`timescale 1ns/100ps
module flash_fetch_prefetch_ctrl_test;
  import ffp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  ffp_req_s req = '0;
  logic disc = 1'b0, sel = 1'b0, wr = 1'b0, wide = 1'b0, dbg = 1'b0, unl = 1'b0, lck = 1'b0;
  logic [15:0] radr = 16'h0;
  logic [31:0] wdat = 32'h0;
  logic ready, arr_req, arr_otp;
  logic [63:0] rdata, arr_d;
  logic [31:0] reg_rd;
  logic [18:0] arr_wa;
  int errors = 0;
  int tests_run = 0;
  // Clock at 125 MHz.
  always #4 clk = ~clk;
  ffp_fetch_ctrl dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .REQ_I(req), .DISCONT_I(disc),
    .READY_O(ready), .RDATA_O(rdata), .REG_SEL_I(sel), .REG_WR_I(wr), .REG_WIDE_I(wide),
    .REG_DEBUG_I(dbg), .UNLOCK_I(unl), .LOCK_I(lck), .REG_ADDR_I(radr), .REG_WDATA_I(wdat),
    .REG_RDATA_O(reg_rd), .ARR_REQ_O(arr_req), .ARR_OTP_O(arr_otp), .ARR_WADDR_O(arr_wa),
    .ARR_DATA_I(arr_d));
  ffp_flash_model flash_u (.clk_i(clk), .arr_req_i(arr_req), .arr_otp_i(arr_otp),
    .arr_waddr_i(arr_wa), .arr_data_o(arr_d));
  ////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compares one value and reports a difference.
  task automatic cmp(input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Expected array word for a fetch or read address.
  function automatic logic [63:0] word(input logic otp, input logic [21:0] a);
    return {otp, 12'h0, a[20:2], 13'h0, ~a[20:2]};
  endfunction
  // One register access of one cycle; read data is taken a cycle later.
  task automatic reg_acc(input logic w, input logic wd, input logic d, input logic [15:0] a,
                         input logic [31:0] wv, output logic [31:0] rv);
    @(posedge clk);
    {sel, wr, wide, dbg} <= {1'b1, w, wd, d};
    radr <= a;
    wdat <= wv;
    @(posedge clk);
    sel <= 1'b0;
    #1 rv = reg_rd;
  endtask
  // Pulses the unlock or the lock line for one cycle.
  task automatic pulse(input logic u);
    @(posedge clk);
    {unl, lck} <= {u, !u};
    @(posedge clk);
    {unl, lck} <= 2'h0;
  endtask
  // Holds a memory request until ready is sampled, with a bounded wait.
  task automatic mem(input logic [2:0] k, input logic [21:0] a, input logic dc, input logic want,
                     output logic [63:0] d);
    logic got;
    got = 1'b0;
    d = '0;
    @(posedge clk);
    req <= {k, a};
    disc <= dc;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge clk);
      disc <= 1'b0;
      if (ready === 1'b1) begin
        got = 1'b1;
        d = rdata;
      end
    end
    req <= '0;
    cmp(want, got);
    if (want && !got) end_sim();
  endtask
  // Fetch or data read whose word is checked.
  task automatic go(input logic [2:0] k, input logic [21:0] a, input logic dc);
    logic [63:0] d;
    mem(k, a, dc, 1'b1, d);
    cmp(word(a >= FFP_OTP_LO, a), d);
  endtask
  ////////////////////////////////////////////////////////////
  // Reset values, write lock, debug path and wide accesses.
  task automatic t_regs();
    logic [31:0] v;
    reg_acc(1'h0, 1'h1, 1'h0, FFP_OFS_ARRAY_WS, 32'h0, v);
    cmp({FFP_RST_OTP_WS, FFP_RST_ARRAY_WS}, v);
    reg_acc(1'h0, 1'h1, 1'h0, FFP_OFS_SLP_STBY, 32'h0, v);
    cmp({FFP_RST_STBY_ACT, FFP_RST_SLP_STBY}, v);
    reg_acc(1'h1, 1'h0, 1'h0, FFP_OFS_OPTION, 32'h1, v);
    reg_acc(1'h0, 1'h0, 1'h0, FFP_OFS_OPTION, 32'h0, v);
    cmp(FFP_RST_OPTION, v[15:0]);
    reg_acc(1'h1, 1'h0, 1'h1, FFP_OFS_OTP_WS, 32'h3, v);
    reg_acc(1'h0, 1'h0, 1'h0, FFP_OFS_OTP_WS, 32'h0, v);
    cmp(16'h0003, v[15:0]);
    $display("t_regs finished");
  endtask
  // Fetches with the pipeline off go to the array, aligned.
  task automatic t_fetch();
    go(3'h4, 22'h300006, 1'h1);
    go(3'h4, 22'h300006, 1'h0);
    go(3'h4, 22'h300009, 1'h0);
    $display("t_fetch finished");
  endtask
  // Clock enable low freezes the block, so a held fetch gets no answer.
  task automatic t_freeze();
    logic [63:0] d;
    @(posedge clk);
    ce <= 1'b0;
    mem(3'h4, 22'h300006, 1'h0, 1'h0, d);
    ce <= 1'b1;
    $display("t_freeze finished");
  endtask
  // Enables the pipeline, then mixes fetches, reads, writes and branches.
  task automatic t_pipe();
    logic [31:0] v;
    logic [63:0] d;
    pulse(1'h1);
    reg_acc(1'h1, 1'h1, 1'h0, FFP_OFS_ARRAY_WS, 32'h0003_0101, v);
    reg_acc(1'h1, 1'h0, 1'h0, FFP_OFS_RSVD, 32'hFFFF, v);
    reg_acc(1'h0, 1'h0, 1'h0, FFP_OFS_OPTION, 32'h0, v);
    cmp(16'h0000, v[15:0]);
    reg_acc(1'h1, 1'h0, 1'h0, FFP_OFS_OPTION, 32'h1, v);
    pulse(1'h0);
    reg_acc(1'h1, 1'h0, 1'h0, FFP_OFS_OPTION, 32'h0, v);
    reg_acc(1'h0, 1'h0, 1'h0, FFP_OFS_OPTION, 32'h0, v);
    cmp(16'h0001, v[15:0]);
    repeat (8) @(posedge clk);
    reg_acc(1'h0, 1'h1, 1'h0, FFP_OFS_ARRAY_WS, 32'h0, v);
    cmp(32'h0003_0101, v);
    go(3'h4, 22'h300011, 1'h1);
    go(3'h4, 22'h300014, 1'h0);
    go(3'h2, 22'h300203, 1'h0);
    go(3'h4, 22'h30001A, 1'h0);
    mem(3'h1, 22'h300020, 1'h0, 1'h1, d);
    go(3'h4, 22'h30001C, 1'h0);
    go(3'h4, FFP_OTP_LO + 22'h5, 1'h1);
    mem(3'h4, 22'h000100, 1'h1, 1'h0, d);
    go(3'h4, 22'h300040, 1'h1);
    go(3'h2, FFP_OTP_LO, 1'h0);
    $display("t_pipe finished");
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_fetch();
    t_freeze();
    t_pipe();
    end_sim();
  end
endmodule
